/* include/psbl_pkg.sv */
// Constants and types for the pseudo-static RAM access control core.
// Assumes a 250 MHz system clock; pins are sampled in that domain.
package psbl_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ        = 250;
  localparam int PD_ENTRY_NS    = 3000;
  localparam int PD_ENTRY_CYC   = (PD_ENTRY_NS * CLK_MHZ) / 1000;
  localparam logic [9:0] PD_ENTRY_CNT = 10'(PD_ENTRY_CYC);

  // ==========================================================
  // Access config word fields and reset value
  localparam logic [15:0] ACC_CFG_RST = 16'h8f2f;
  localparam int ACC_PD_BIT     = 15;
  localparam int ACC_DRV_HI     = 14;
  localparam int ACC_DRV_LO     = 12;
  localparam int ACC_LAT_HI     = 7;
  localparam int ACC_LAT_LO     = 4;
  localparam int ACC_FIXED_BIT  = 3;
  localparam int ACC_LEGACY_BIT = 2;
  localparam int ACC_BL_HI      = 1;
  localparam int ACC_BL_LO      = 0;

  // ==========================================================
  // Refresh config word fields and reset value
  localparam logic [15:0] REF_CFG_RST = 16'hffc1;
  localparam logic [15:0] REF_RO_MASK = 16'h0003;
  localparam int REF_LINEAR_BIT = 7;

  // ==========================================================
  // Burst length codes
  localparam logic [1:0] BL_128 = 2'h0;
  localparam logic [1:0] BL_64  = 2'h1;
  localparam logic [1:0] BL_16  = 2'h2;
  localparam logic [1:0] BL_32  = 2'h3;

  // ==========================================================
  // Initial latency codes; clock counts are decoded in psbl_core
  localparam logic [3:0] LAT_C5 = 4'h0;
  localparam logic [3:0] LAT_C6 = 4'h1;
  localparam logic [3:0] LAT_C7 = 4'h2;
  localparam logic [3:0] LAT_C3 = 4'he;
  localparam logic [3:0] LAT_C4 = 4'hf;

  localparam logic [31:0] WORD_BYTES = 32'h2;
  localparam logic        REG_SEL_ACC = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CA, ST_REG_WR, ST_LAT, ST_DATA, ST_PD_ENTRY, ST_PD
  } psbl_state_e;
endpackage

/* core/psbl_core.sv */
// Access control core: burst sequencing, latency, power down, config.
// Assumes a command decoder on i_clk_sys supplies decoded CA fields;
// CK, CS# and RESET# arrive as raw pins and are synchronised here.
`timescale 1ns/1ns
module psbl_core (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ck,
  input  wire logic        i_cs_n,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_refresh_pending,
  input  wire logic        i_ca_valid,
  input  wire logic        i_ca_read,
  input  wire logic        i_ca_reg,
  input  wire logic        i_ca_wrap,
  input  wire logic [31:0] i_ca_addr,
  input  wire logic        i_reg_wr_valid,
  input  wire logic        i_reg_wr_sel,
  input  wire logic [15:0] i_reg_wr_data,
  output logic             o_rwds,
  output logic             o_rwds_oe,
  output logic             o_data_phase,
  output logic [31:0]      o_word_addr,
  output logic             o_reg_wr_capture,
  output logic [15:0]      o_access_config,
  output logic [15:0]      o_refresh_config,
  output logic [2:0]       o_drive_strength,
  output logic             o_refresh_enable,
  output logic             o_deep_power_down_state,
  output logic             o_array_invalid
);
  // ==========================================================
  // Decode functions
  function automatic logic [7:0] grp_mask(input logic [1:0] bl);
    unique case (bl)
      psbl_pkg::BL_128: grp_mask = 8'h7f;
      psbl_pkg::BL_64:  grp_mask = 8'h3f;
      psbl_pkg::BL_16:  grp_mask = 8'h0f;
      psbl_pkg::BL_32:  grp_mask = 8'h1f;
    endcase
  endfunction

  function automatic logic [3:0] lat_clocks(input logic [3:0] code);
    case (code)
      psbl_pkg::LAT_C3: lat_clocks = 4'h3;
      psbl_pkg::LAT_C4: lat_clocks = 4'h4;
      psbl_pkg::LAT_C5: lat_clocks = 4'h5;
      psbl_pkg::LAT_C6: lat_clocks = 4'h6;
      default:          lat_clocks = 4'h7;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic ck_s1, ck_s2, ck_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic rp_s1, rp_s2;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      {ck_s1, ck_s2, ck_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {rp_s1, rp_s2}        <= 2'h3;
    end else begin
      {ck_s1, ck_s2, ck_s3} <= {i_ck, ck_s1, ck_s2};
      {cs_s1, cs_s2, cs_s3} <= {i_cs_n, cs_s1, cs_s2};
      {rp_s1, rp_s2}        <= {i_reset_pin_n, rp_s1};
    end
  end

  wire ck_rise  = ck_s2 & ~ck_s3;
  wire cs_fall  = ~cs_s2 & cs_s3;
  wire cs_high  = cs_s2;
  wire cfg_rst  = ~i_rst_n | ~rp_s2;

  // ==========================================================
  // State and datapath registers
  psbl_pkg::psbl_state_e state, next_state;
  logic [15:0] acc_cfg;
  logic [15:0] ref_cfg;
  logic [31:0] addr;
  logic [31:0] grp_base;
  logic [6:0]  word_cnt;
  logic        wrap_done;
  logic        linear_mode;
  logic        double_lat;
  logic [3:0]  lat_left;
  logic [9:0]  pd_cnt;
  logic        cs_low_seen;

  // State decode
  wire st_idle     = state == psbl_pkg::ST_IDLE;
  wire st_ca       = state == psbl_pkg::ST_CA;
  wire st_reg_wr   = state == psbl_pkg::ST_REG_WR;
  wire st_lat      = state == psbl_pkg::ST_LAT;
  wire st_data     = state == psbl_pkg::ST_DATA;
  wire st_pd_entry = state == psbl_pkg::ST_PD_ENTRY;
  wire st_pd       = state == psbl_pkg::ST_PD;
  wire to_ca       = next_state == psbl_pkg::ST_CA;
  wire to_data     = next_state == psbl_pkg::ST_DATA;
  wire to_pd       = next_state == psbl_pkg::ST_PD;
  wire pd_leave    = st_pd & (next_state == psbl_pkg::ST_IDLE);

  // ==========================================================
  // Configuration decode
  wire [7:0]  mask      = grp_mask(acc_cfg[psbl_pkg::ACC_BL_HI:
                                           psbl_pkg::ACC_BL_LO]);
  wire [3:0]  lat_sel   = lat_clocks(acc_cfg[psbl_pkg::ACC_LAT_HI:
                                             psbl_pkg::ACC_LAT_LO]);
  wire        fixed_lat = acc_cfg[psbl_pkg::ACC_FIXED_BIT];
  wire        hybrid    = ~acc_cfg[psbl_pkg::ACC_LEGACY_BIT];
  wire        cfg_lin   = ref_cfg[psbl_pkg::REF_LINEAR_BIT];
  wire        rwds_ca   = fixed_lat | i_refresh_pending;
  wire        rwds_hold = st_ca ? double_lat : rwds_ca;
  wire [3:0]  lat_load  = double_lat ? 4'(lat_sel << 1) : lat_sel;
  wire        reg_write = i_ca_reg & ~i_ca_read;

  // ==========================================================
  // Burst address sequencing
  wire [31:0] mask32    = {24'h0, mask};
  wire [31:0] addr_inc  = addr + psbl_pkg::WORD_BYTES;
  wire [31:0] wrap_next = (addr & ~mask32) | (addr_inc & mask32);
  wire [31:0] hyb_jump  = grp_base + mask32 + 32'h1;
  wire        last_wrap = word_cnt == 7'(mask >> 1);
  wire        jump_now  = hybrid & ~wrap_done & last_wrap;
  wire        run_lin   = linear_mode | (hybrid & wrap_done);
  wire [31:0] next_addr = run_lin  ? addr_inc :
                          jump_now ? hyb_jump : wrap_next;

  wire pd_req = i_reg_wr_valid & (i_reg_wr_sel == psbl_pkg::REG_SEL_ACC)
              & ~i_reg_wr_data[psbl_pkg::ACC_PD_BIT];

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      psbl_pkg::ST_IDLE:
        if (cs_fall)
          next_state = psbl_pkg::ST_CA;
      psbl_pkg::ST_CA:
        if (cs_high)
          next_state = psbl_pkg::ST_IDLE;
        else if (i_ca_valid)
          next_state = reg_write ? psbl_pkg::ST_REG_WR
                                 : psbl_pkg::ST_LAT;
      psbl_pkg::ST_REG_WR:
        if (pd_req)
          next_state = psbl_pkg::ST_PD_ENTRY;
        else if (cs_high)
          next_state = psbl_pkg::ST_IDLE;
      psbl_pkg::ST_LAT:
        if (cs_high)
          next_state = psbl_pkg::ST_IDLE;
        else if (ck_rise && lat_left == 4'h1)
          next_state = psbl_pkg::ST_DATA;
      psbl_pkg::ST_DATA:
        if (cs_high)
          next_state = psbl_pkg::ST_IDLE;
      psbl_pkg::ST_PD_ENTRY:
        if (pd_cnt == psbl_pkg::PD_ENTRY_CNT)
          next_state = psbl_pkg::ST_PD;
      psbl_pkg::ST_PD:
        if (cs_low_seen && cs_high)
          next_state = psbl_pkg::ST_IDLE;
      default:
        next_state = psbl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (cfg_rst)
      state <= psbl_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // Transaction registers
  always_ff @(posedge i_clk_sys) begin
    if (cfg_rst) begin
      double_lat  <= 1'b0;
      linear_mode <= 1'b1;
      lat_left    <= 4'h0;
      addr        <= 32'h0;
      grp_base    <= 32'h0;
      word_cnt    <= 7'h0;
      wrap_done   <= 1'b0;
    end else if (st_idle && cs_fall) begin
      double_lat  <= rwds_ca;
    end else if (st_ca && i_ca_valid) begin
      lat_left    <= lat_load;
      linear_mode <= cfg_lin | ~i_ca_wrap;
      addr        <= i_ca_addr;
      grp_base    <= i_ca_addr & ~mask32;
      word_cnt    <= 7'h0;
      wrap_done   <= 1'b0;
    end else if (st_lat && ck_rise) begin
      lat_left    <= lat_left - 4'h1;
    end else if (st_data && ck_rise) begin
      addr        <= next_addr;
      word_cnt    <= word_cnt + 7'h1;
      wrap_done   <= wrap_done | jump_now;
    end
  end

  // ==========================================================
  // Configuration words and power down
  always_ff @(posedge i_clk_sys) begin
    if (cfg_rst) begin
      acc_cfg     <= psbl_pkg::ACC_CFG_RST;
      ref_cfg     <= psbl_pkg::REF_CFG_RST;
      pd_cnt      <= 10'h0;
      cs_low_seen <= 1'b0;
    end else begin
      if (st_reg_wr && i_reg_wr_valid) begin
        if (i_reg_wr_sel == psbl_pkg::REG_SEL_ACC)
          acc_cfg <= i_reg_wr_data;
        else
          ref_cfg <= (i_reg_wr_data & ~psbl_pkg::REF_RO_MASK) |
                     (psbl_pkg::REF_CFG_RST & psbl_pkg::REF_RO_MASK);
      end
      if (st_pd_entry)
        pd_cnt <= pd_cnt + 10'h1;
      else
        pd_cnt <= 10'h0;
      if (st_pd && !cs_high)
        cs_low_seen <= 1'b1;
      else if (!st_pd)
        cs_low_seen <= 1'b0;
      if (pd_leave)
        acc_cfg[psbl_pkg::ACC_PD_BIT] <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rwds                  <= 1'b0;
      o_rwds_oe               <= 1'b0;
      o_data_phase            <= 1'b0;
      o_word_addr             <= 32'h0;
      o_reg_wr_capture        <= 1'b0;
      o_refresh_enable        <= 1'b1;
      o_deep_power_down_state <= 1'b0;
      o_array_invalid         <= 1'b0;
    end else begin
      o_rwds           <= to_ca & rwds_hold;
      o_rwds_oe        <= to_ca;
      o_data_phase     <= to_data;
      o_word_addr      <= (st_data && ck_rise) ? next_addr : addr;
      o_reg_wr_capture <= st_reg_wr & i_reg_wr_valid;
      o_refresh_enable <= ~to_pd;
      o_deep_power_down_state <= to_pd;
      if (to_pd)
        o_array_invalid <= 1'b1;
    end
  end

  assign o_access_config  = acc_cfg;
  assign o_refresh_config = ref_cfg;
  assign o_drive_strength = acc_cfg[psbl_pkg::ACC_DRV_HI:
                                    psbl_pkg::ACC_DRV_LO];

  // ==========================================================
  // Assertions
  localparam int PD_WAIT = 760;

  rwds_fixed_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    (st_idle && cs_fall && fixed_lat) |=> (o_rwds && o_rwds_oe))
    else $error("RWDS not high in CA with fixed latency");

  rwds_refresh_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    (st_idle && cs_fall && i_refresh_pending) |=> o_rwds)
    else $error("RWDS not high for pending refresh");

  reg_wr_zero_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    (st_ca && !cs_high && i_ca_valid && reg_write)
      |=> st_reg_wr)
    else $error("Register write did not skip latency");

  lat_load_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    (st_ca && !cs_high && i_ca_valid && !reg_write)
      |=> lat_left == (double_lat ? 4'($past(lat_sel) << 1)
                                  : $past(lat_sel)))
    else $error("Initial latency count wrong");

  wrap_group_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    (st_data && ck_rise && !linear_mode && !hybrid)
      |=> (addr & ~mask32) == $past(addr & ~mask32))
    else $error("Legacy wrap left its group");

  hybrid_jump_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    (st_data && ck_rise && jump_now && !linear_mode)
      |=> addr == $past(grp_base) + $past(mask32) + 32'h1)
    else $error("Hybrid burst did not jump to next group");

  pd_entry_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n || !rp_s2)
    $rose(st_pd_entry) |-> ##[1:PD_WAIT] o_deep_power_down_state)
    else $error("Power down not entered in time");

  pd_refresh_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    o_deep_power_down_state |-> (!o_refresh_enable && o_array_invalid))
    else $error("Refresh running in power down");

  pd_exit_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $fell(o_deep_power_down_state) |-> acc_cfg[psbl_pkg::ACC_PD_BIT])
    else $error("Power down bit not restored on exit");

  reset_cfg_a: assert property (@(posedge i_clk_sys)
    $past(!i_rst_n) |-> acc_cfg == psbl_pkg::ACC_CFG_RST)
    else $error("Access config not at reset value");

  hybrid_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_data && ck_rise && jump_now);
  pd_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $fell(o_deep_power_down_state));
  reg_wr_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_reg_wr_capture);
  refresh_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    st_lat && !fixed_lat && double_lat);
endmodule

/* sim/psbl_host_model.sv */
// Host link model: CS#, CK and decoded CA and register-write strobes.
// Assumes the bench owns the system clock and both reset pins.
`timescale 1ns/1ns
module psbl_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rwds,
  input  wire logic        i_rwds_oe,
  input  wire logic        i_data_phase,
  input  wire logic [31:0] i_word_addr,
  input  wire logic        i_reg_wr_capture,
  output logic             o_ck,
  output logic             o_cs_n,
  output logic             o_ca_valid,
  output logic             o_ca_read,
  output logic             o_ca_reg,
  output logic             o_ca_wrap,
  output logic [31:0]      o_ca_addr,
  output logic             o_reg_wr_valid,
  output logic             o_reg_wr_sel,
  output logic [15:0]      o_reg_wr_data
);
  logic [31:0] addr_log [72];
  logic        rwds_seen, oe_seen, cap_seen;
  int          lat_seen, got;
  initial begin
    {o_ck, o_ca_valid, o_ca_read, o_ca_reg, o_ca_wrap} = 5'h0;
    {o_reg_wr_valid, o_reg_wr_sel, o_reg_wr_data, o_ca_addr} = '0;
    o_cs_n = 1'b1;
  end
  // ==========================================================
  // Frame open and close
  task automatic open_frame(logic rd, logic rg, logic wr, logic [31:0] a);
    o_cs_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    rwds_seen = i_rwds;
    oe_seen = i_rwds_oe;
    @(posedge i_clk_sys);
    {o_ca_valid, o_ca_read, o_ca_reg, o_ca_wrap} <= {1'b1, rd, rg, wr};
    o_ca_addr <= a;
    @(posedge i_clk_sys);
    o_ca_valid <= 1'b0;
  endtask
  task automatic close_frame();
    @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
  endtask
  // ==========================================================
  // Transfers
  task automatic reg_write(logic sel, logic [15:0] d);
    cap_seen = 1'b0;
    open_frame(1'b0, 1'b1, 1'b0, 32'h0);
    @(posedge i_clk_sys);
    {o_reg_wr_valid, o_reg_wr_sel, o_reg_wr_data} <= {1'b1, sel, d};
    @(posedge i_clk_sys);
    o_reg_wr_valid <= 1'b0;
    repeat (3) begin
      #1;
      cap_seen = cap_seen | i_reg_wr_capture;
      @(posedge i_clk_sys);
    end
    close_frame();
  endtask
  task automatic burst(logic rd, logic rg, logic wr, logic [31:0] a, int n);
    lat_seen = 0;
    got = 0;
    open_frame(rd, rg, wr, a);
    repeat (3) @(posedge i_clk_sys);
    #1;
    for (int k = 1; k <= n + 16 && got < n; k++) begin
      o_ck = 1'b1;
      #16 o_ck = 1'b0;
      #12;
      if (i_data_phase === 1'b1) begin
        if (got == 0) lat_seen = k;
        addr_log[got] = i_word_addr;
        got++;
      end
      #4;
    end
    close_frame();
  endtask
  task automatic stray(logic [15:0] d);
    {o_ca_valid, o_ca_reg, o_reg_wr_valid, o_reg_wr_data} <= {3'h7, d};
    @(posedge i_clk_sys);
    {o_ca_valid, o_reg_wr_valid} <= 2'h0;
  endtask
endmodule

/* sim/psbl_core_tb.sv */
// Bench for psbl_core: random and corner bursts, config, power down.
// Assumes psbl_host_model plays the host on the link side.
`timescale 1ns/1ns
module psbl_core_tb;
  logic        i_clk_sys, i_rst_n, i_reset_pin_n, i_refresh_pending;
  logic        i_ck, i_cs_n, i_ca_valid, i_ca_read, i_ca_reg, i_ca_wrap;
  logic        i_reg_wr_valid, i_reg_wr_sel, fx;
  logic [31:0] i_ca_addr, o_word_addr, sa;
  logic [15:0] i_reg_wr_data, o_access_config, o_refresh_config, acc;
  logic [2:0]  o_drive_strength, drv;
  logic        o_rwds, o_rwds_oe, o_data_phase, o_reg_wr_capture;
  logic        o_refresh_enable, o_deep_power_down_state, o_array_invalid;
  int          err_total = 0;
  int          checked = 0;
  int          lc, n, exp_lat;
  localparam logic [3:0] LCODE [5] = '{4'h0, 4'h1, 4'h2, 4'he, 4'hf};
  localparam int         LCLK  [5] = '{5, 6, 7, 3, 4};
  psbl_core DUT (
    .i_clk_sys, .i_rst_n, .i_ck, .i_cs_n, .i_reset_pin_n,
    .i_refresh_pending, .i_ca_valid, .i_ca_read, .i_ca_reg, .i_ca_wrap,
    .i_ca_addr, .i_reg_wr_valid, .i_reg_wr_sel, .i_reg_wr_data, .o_rwds,
    .o_rwds_oe, .o_data_phase, .o_word_addr, .o_reg_wr_capture,
    .o_access_config, .o_refresh_config, .o_drive_strength,
    .o_refresh_enable, .o_deep_power_down_state, .o_array_invalid
  );
  psbl_host_model host (
    .i_clk_sys, .i_rwds(o_rwds), .i_rwds_oe(o_rwds_oe),
    .i_data_phase(o_data_phase), .i_word_addr(o_word_addr),
    .i_reg_wr_capture(o_reg_wr_capture), .o_ck(i_ck), .o_cs_n(i_cs_n),
    .o_ca_valid(i_ca_valid), .o_ca_read(i_ca_read), .o_ca_reg(i_ca_reg),
    .o_ca_wrap(i_ca_wrap), .o_ca_addr(i_ca_addr),
    .o_reg_wr_valid(i_reg_wr_valid), .o_reg_wr_sel(i_reg_wr_sel),
    .o_reg_wr_data(i_reg_wr_data)
  );
  always #2 i_clk_sys = ~i_clk_sys;
  // ==========================================================
  // Compare, verdict and expectations
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] exp_addr(logic [31:0] s, int i,
      logic wr, logic leg, logic [1:0] bl);
    logic [31:0] g;
    logic [31:0] b;
    g = (bl == 2'h0) ? 32'h80 : (bl == 2'h1) ? 32'h40 :
        (bl == 2'h2) ? 32'h10 : 32'h20;
    b = s & ~(g - 32'h1);
    if (!wr) return s + 32'(2 * i);
    if (leg || 32'(2 * i) < g) begin
      return b + ((s - b + 32'(2 * i)) % g);
    end
    return b + 32'(2 * i);
  endfunction
  task automatic run(logic rd, logic rg, logic wr, logic leg, logic [1:0] bl);
    host.burst(rd, rg, wr, sa, n);
    if (host.got < n) begin
      err_total++;
      complete_run();
    end
    check({31'h0, host.oe_seen}, 32'h1);
    check({31'h0, host.rwds_seen}, {31'h0, fx | i_refresh_pending});
    exp_lat = (fx | i_refresh_pending) ? 2 * lc : lc;
    check(32'(host.lat_seen), 32'(exp_lat));
    for (int k = 0; k < n; k++) begin
      check(host.addr_log[k], exp_addr(sa, k, wr, leg, bl));
    end
    check({31'h0, o_data_phase}, 32'h0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {i_clk_sys, i_rst_n, i_reset_pin_n, i_refresh_pending} = 4'h2;
    sa = $urandom(32'hc986);
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    check(o_drive_strength, 3'h0);
    check(o_access_config[7:4], 4'h2);
    check(o_access_config[3], 1'b1);
    check(o_access_config[2], 1'b1);
    check(o_access_config[1:0], 2'h3);
    check(o_refresh_config[7], 1'b1);
    i_refresh_pending <= 1'b1;
    host.reg_write(1'b1, 16'hff42);
    check(host.cap_seen, 1'b1);
    check(o_refresh_config, 16'hff41);
    for (int c = 0; c < 10; c++) begin
      drv = 3'($urandom);
      fx = c[0];
      acc = {1'b1, drv, 4'hf, LCODE[c / 2], fx, 1'b1, 2'h3};
      host.reg_write(1'b0, acc);
      check(o_access_config, acc);
      check(o_drive_strength, drv);
      i_refresh_pending <= 1'($urandom);
      sa = $urandom & 32'h00ff_fffe;
      lc = LCLK[c / 2];
      n = 3;
      run(1'($urandom) | c[2], c[2], 1'b0, 1'b1, 2'h3);
    end
    {fx, lc} = {1'b0, 32'h3};
    i_refresh_pending <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      host.reg_write(1'b0, {8'h8f, LCODE[3], 1'b0, c[2], c[1:0]});
      n = (c[1:0] == 0) ? 64 : (c[1:0] == 1) ? 32 : (c[1:0] == 2) ? 8 : 16;
      n = n + 4;
      sa = $urandom & 32'h00ff_ff00;
      sa = sa | (c[0] ? 32'h7e : $urandom & 32'h7e);
      run(1'b1, 1'b0, 1'b1, c[2], c[1:0]);
    end
    host.reg_write(1'b0, 16'h0f2f);
    for (lc = 0; lc < 800 && o_deep_power_down_state !== 1'b1; lc++) begin
      @(posedge i_clk_sys);
    end
    check({31'h0, lc > 700 && lc < 800}, 32'h1);
    if (o_deep_power_down_state !== 1'b1) begin
      complete_run();
    end
    check({o_refresh_enable, o_array_invalid}, 2'h1);
    host.stray(16'h8f2f);
    repeat (4) @(posedge i_clk_sys);
    check({o_access_config[15], o_deep_power_down_state}, 2'h1);
    host.open_frame(1'b1, 1'b0, 1'b0, 32'h0);
    host.close_frame();
    check(o_deep_power_down_state, 1'b0);
    check(o_access_config[15], 1'b1);
    check({o_refresh_enable, o_array_invalid}, 2'h3);
    host.reg_write(1'b0, 16'hdf0b);
    i_reset_pin_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_reset_pin_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    check(o_access_config, 16'h8f2f);
    check(o_refresh_config[7], 1'b1);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    check(o_array_invalid, 1'b0);
    complete_run();
  end
endmodule
